// ---- design/dct_host_ctrl.v ----
// host-side command scheduler enforcing dram core timing and data placement
`timescale 1ns/1ps
`default_nettype none
`include "dct_timing_regs.vh"

module dct_host_ctrl (
  input  wire        core_clk_in,
  input  wire        arst_n_in,
  input  wire [1:0]  bin_sel_in,
  input  wire        eraw_en_in,
  input  wire        req_valid_in,
  input  wire [3:0]  req_cmd_in,
  input  wire [2:0]  req_bank_in,
  input  wire [31:0] req_wdata_in,
  output wire        req_ready_out,
  output reg  [31:0] rd_data_out,
  output reg         rd_valid_out,
  input  wire        pdn_req_in,
  output reg         pdn_state_out,
  output reg         dev_pdn_out,
  output reg         dev_cmd_valid_out,
  output reg  [3:0]  dev_cmd_out,
  output reg  [2:0]  dev_bank_out,
  input  wire [15:0] dq_in,
  output reg  [15:0] dq_out,
  output reg         dq_oe_out
);

  // minimum for the selected bin from a {C, B, A} table
  function [5:0] pick;
    input [1:0]  bin;
    input [17:0] vals;
    begin
      case (bin)
        `DCT_BIN_B: pick = vals[11:6];
        `DCT_BIN_C: pick = vals[17:12];
        default:    pick = vals[5:0];
      endcase
    end
  endfunction

  // saturating history counter step
  function [5:0] step;
    input [5:0] c;
    begin
      step = (c == `DCT_CNT_MAX) ? c : c + 6'h01;
    end
  endfunction

  // bank set of a bank
  function bset;
    input [2:0] b;
    begin
      bset = b[0];
    end
  endfunction

  function [5:0] max6;
    input [5:0] a;
    input [5:0] b;
    begin
      max6 = (a > b) ? a : b;
    end
  endfunction

  // per-bin tables, {C, B, A}
  localparam [17:0] T_RC      = `DCT_T_RC;
  localparam [17:0] T_RC_ERAW = `DCT_T_RC_ERAW;
  localparam [17:0] T_RAS     = `DCT_T_RAS;
  localparam [17:0] T_RCDR    = `DCT_T_RCDR;
  localparam [17:0] T_RCDW    = `DCT_T_RCDW;
  localparam [17:0] T_CAC     = `DCT_T_CAC;
  localparam [17:0] T_WR      = `DCT_T_WR;
  localparam [17:0] T_RW      = `DCT_T_RW;
  localparam [17:0] T_RDP     = `DCT_T_RDP;
  localparam [17:0] T_WRP     = `DCT_T_WRP;
  localparam [17:0] T_DR      = `DCT_T_DR;
  localparam [17:0] T_DP      = `DCT_T_DP;
  localparam [17:0] T_LRR     = `DCT_T_LRR;

  // power-down sequencing states
  localparam [2:0] PS_RUN   = 3'b001;
  localparam [2:0] PS_ENTRY = 3'b010;
  localparam [2:0] PS_DOWN  = 3'b100;

  integer i;
  integer j;

  // per-bank history: cycles since last event, open flag and writes since activate
  reg [5:0] act_cnt_r [0:7];
  reg [5:0] rd_cnt_r  [0:7];
  reg [5:0] wr_cnt_r  [0:7];
  reg [7:0] open_r;
  reg [7:0] wr1_r;
  reg [7:0] wr2_r;

  // global and per-set history
  reg [5:0] act_any_r;
  reg [5:0] pre_any_r;
  reg       pre_set_r;
  reg [5:0] rd_any_r;
  reg [5:0] wr_any_r;
  reg       wr_set_r;
  reg [5:0] lrr_any_r;
  reg [5:0] refx_any_r;

  // data placement pipelines
  reg [`DCT_PIPE_W-1:0] rd_pipe_r;
  reg [3:0]             wr_pipe_r;
  reg [31:0]            wd_pipe_r [0:3];
  reg [15:0]            dq_meta_r;
  reg [15:0]            dq_sync_r;
  reg [15:0]            rd_lo_r;

  reg [2:0] ps_r;
  reg [5:0] pdn_cnt_r;

  reg        legal;
  reg [5:0]  rc_min;
  reg [5:0]  rw_min;
  reg [5:0]  cac;
  wire [2:0] bk    = req_bank_in;
  wire       set_q = bset(req_bank_in);

  wire is_act = (req_cmd_in == `DCT_CMD_ACT) | (req_cmd_in == `DCT_CMD_REFA) |
                (req_cmd_in == `DCT_CMD_REFI);
  wire is_pre = (req_cmd_in == `DCT_CMD_PRE) | (req_cmd_in == `DCT_CMD_REFP);
  wire is_rd  = (req_cmd_in == `DCT_CMD_RD);
  wire is_wr  = (req_cmd_in == `DCT_CMD_WR) | (req_cmd_in == `DCT_CMD_WRM);
  wire is_rfx = (req_cmd_in == `DCT_CMD_REFA) | (req_cmd_in == `DCT_CMD_REF1) |
                (req_cmd_in == `DCT_CMD_REFP);
  wire is_lrr = (req_cmd_in == `DCT_CMD_LRR);

  // legality check against all history before issue
  always @* begin
    legal  = 1'b1;
    cac    = pick(bin_sel_in, T_CAC);
    rc_min = pick(bin_sel_in, T_RC);
    if (eraw_en_in && wr2_r[bk])
      rc_min = max6(rc_min, pick(bin_sel_in, T_RC_ERAW));
    rw_min = max6(pick(bin_sel_in, T_RW), cac + `DCT_T_CC + `DCT_T_BUB - `DCT_T_CWD);
    if (is_act) begin
      if (open_r[bk])
        legal = 1'b0;
      if (act_cnt_r[bk] < rc_min)
        legal = 1'b0;
      if (act_any_r < `DCT_T_RR)
        legal = 1'b0;
    end
    if (is_pre) begin
      if (!open_r[bk])
        legal = 1'b0;
      if (act_cnt_r[bk] < pick(bin_sel_in, T_RAS))
        legal = 1'b0;
      if (pre_any_r < ((set_q == pre_set_r) ? `DCT_T_PP : `DCT_T_PP_D))
        legal = 1'b0;
      if (rd_cnt_r[bk] < pick(bin_sel_in, T_RDP))
        legal = 1'b0;
      if (wr_cnt_r[bk] < pick(bin_sel_in, T_WRP))
        legal = 1'b0;
      if (wr_cnt_r[bk] < `DCT_T_CWD + pick(bin_sel_in, T_DP))
        legal = 1'b0;
    end
    if (is_rd) begin
      if (!open_r[bk])
        legal = 1'b0;
      if (act_cnt_r[bk] < pick(bin_sel_in, T_RCDR))
        legal = 1'b0;
      if (rd_any_r < `DCT_T_CC)
        legal = 1'b0;
      if (set_q == wr_set_r) begin
        if (wr_any_r < pick(bin_sel_in, T_WR))
          legal = 1'b0;
      end else if (wr_any_r < pick(bin_sel_in, T_WR)) begin
        if (wr_any_r < `DCT_T_WRD_MIN)
          legal = 1'b0;
        if (wr_any_r == 6'h03 || wr_any_r == 6'h05 || wr_any_r == 6'h07)
          legal = 1'b0;
      end
      if (wr_cnt_r[bk] < `DCT_T_CWD + pick(bin_sel_in, T_DR))
        legal = 1'b0;
    end
    if (is_wr) begin
      if (!open_r[bk])
        legal = 1'b0;
      if (act_cnt_r[bk] < pick(bin_sel_in, T_RCDW))
        legal = 1'b0;
      if (wr_any_r < `DCT_T_CC)
        legal = 1'b0;
      if (rd_any_r < rw_min)
        legal = 1'b0;
    end
    if (is_lrr) begin
      if (lrr_any_r < pick(bin_sel_in, T_LRR))
        legal = 1'b0;
      if (refx_any_r < pick(bin_sel_in, T_LRR))
        legal = 1'b0;
    end
    if (ps_r != PS_RUN || pdn_req_in)
      legal = 1'b0;
  end

  assign req_ready_out = legal;
  wire issue = req_valid_in & legal & (req_cmd_in != `DCT_CMD_NOP);

  // command history update
  always @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      for (i = 0; i < 8; i = i + 1) begin
        act_cnt_r[i] <= `DCT_CNT_MAX;
        rd_cnt_r[i]  <= `DCT_CNT_MAX;
        wr_cnt_r[i]  <= `DCT_CNT_MAX;
      end
      open_r     <= 8'h00;
      wr1_r      <= 8'h00;
      wr2_r      <= 8'h00;
      act_any_r  <= `DCT_CNT_MAX;
      pre_any_r  <= `DCT_CNT_MAX;
      pre_set_r  <= 1'b0;
      rd_any_r   <= `DCT_CNT_MAX;
      wr_any_r   <= `DCT_CNT_MAX;
      wr_set_r   <= 1'b0;
      lrr_any_r  <= `DCT_CNT_MAX;
      refx_any_r <= `DCT_CNT_MAX;
    end else begin
      for (i = 0; i < 8; i = i + 1) begin
        act_cnt_r[i] <= step(act_cnt_r[i]);
        rd_cnt_r[i]  <= step(rd_cnt_r[i]);
        wr_cnt_r[i]  <= step(wr_cnt_r[i]);
      end
      act_any_r  <= step(act_any_r);
      pre_any_r  <= step(pre_any_r);
      rd_any_r   <= step(rd_any_r);
      wr_any_r   <= step(wr_any_r);
      lrr_any_r  <= step(lrr_any_r);
      refx_any_r <= step(refx_any_r);
      if (issue) begin
        if (is_act) begin
          act_cnt_r[bk] <= 6'h01;
          act_any_r     <= 6'h01;
          open_r[bk]    <= 1'b1;
          wr1_r[bk]     <= 1'b0;
          wr2_r[bk]     <= 1'b0;
        end
        if (is_pre) begin
          pre_any_r  <= 6'h01;
          pre_set_r  <= set_q;
          open_r[bk] <= 1'b0;
        end
        if (is_rd) begin
          rd_cnt_r[bk] <= 6'h01;
          rd_any_r     <= 6'h01;
        end
        if (is_wr) begin
          wr_cnt_r[bk] <= 6'h01;
          wr_any_r     <= 6'h01;
          wr_set_r     <= set_q;
          wr1_r[bk]    <= 1'b1;
          if (wr1_r[bk])
            wr2_r[bk] <= 1'b1;
        end
        if (is_rfx)
          refx_any_r <= 6'h01;
        if (is_lrr)
          lrr_any_r <= 6'h01;
      end
    end
  end

  // device command pins, registered
  always @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      dev_cmd_valid_out <= 1'b0;
      dev_cmd_out       <= `DCT_CMD_NOP;
      dev_bank_out      <= 3'h0;
    end else begin
      dev_cmd_valid_out <= issue;
      dev_cmd_out       <= issue ? req_cmd_in : `DCT_CMD_NOP;
      dev_bank_out      <= issue ? req_bank_in : 3'h0;
    end
  end

  // write data placement, 3 cycles after the write on the pins
  always @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wr_pipe_r <= 4'h0;
      for (j = 0; j < 4; j = j + 1)
        wd_pipe_r[j] <= 32'h0000_0000;
      dq_out    <= 16'h0000;
      dq_oe_out <= 1'b0;
    end else begin
      wr_pipe_r    <= {wr_pipe_r[2:0], issue & is_wr};
      wd_pipe_r[0] <= req_wdata_in;
      for (j = 1; j < 4; j = j + 1)
        wd_pipe_r[j] <= wd_pipe_r[j-1];
      if (wr_pipe_r[2]) begin
        dq_out    <= wd_pipe_r[2][15:0];
        dq_oe_out <= 1'b1;
      end else if (wr_pipe_r[3]) begin
        dq_out    <= wd_pipe_r[3][31:16];
        dq_oe_out <= 1'b1;
      end else begin
        dq_out    <= 16'h0000;
        dq_oe_out <= 1'b0;
      end
    end
  end

  // read data capture, device latency plus two sync stages
  always @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      dq_meta_r    <= 16'h0000;
      dq_sync_r    <= 16'h0000;
      rd_pipe_r    <= {`DCT_PIPE_W{1'b0}};
      rd_lo_r      <= 16'h0000;
      rd_data_out  <= 32'h0000_0000;
      rd_valid_out <= 1'b0;
    end else begin
      dq_meta_r    <= dq_in;
      dq_sync_r    <= dq_meta_r;
      rd_pipe_r    <= {rd_pipe_r[`DCT_PIPE_W-2:0], issue & is_rd};
      rd_valid_out <= 1'b0;
      if (rd_pipe_r[cac[3:0] + 4'h2])
        rd_lo_r <= dq_sync_r;
      if (rd_pipe_r[cac[3:0] + 4'h3]) begin
        rd_data_out  <= {dq_sync_r, rd_lo_r};
        rd_valid_out <= 1'b1;
      end
    end
  end

  // power-down entry and exit
  always @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ps_r          <= PS_RUN;
      pdn_cnt_r     <= 6'h00;
      dev_pdn_out   <= 1'b0;
      pdn_state_out <= 1'b0;
    end else begin
      case (ps_r)
        PS_RUN: begin
          if (pdn_req_in) begin
            ps_r        <= PS_ENTRY;
            pdn_cnt_r   <= 6'h01;
            dev_pdn_out <= 1'b1;
          end
        end
        PS_ENTRY: begin
          if (!pdn_req_in) begin
            ps_r          <= PS_RUN;
            dev_pdn_out   <= 1'b0;
          end else if (pdn_cnt_r == `DCT_T_PDN_ENTRY) begin
            ps_r          <= PS_DOWN;
            pdn_state_out <= 1'b1;
          end else begin
            pdn_cnt_r <= pdn_cnt_r + 6'h01;
          end
        end
        PS_DOWN: begin
          if (!pdn_req_in) begin
            ps_r          <= PS_RUN;
            dev_pdn_out   <= 1'b0;
            pdn_state_out <= 1'b0;
          end
        end
        default: begin
          ps_r <= PS_RUN;
        end
      endcase
    end
  end

endmodule // dct_host_ctrl

`default_nettype wire

// ---- design/dct_timing_regs.vh ----
// timing constants and command codes for the dram core timing controller
`ifndef DCT_TIMING_REGS_VH
`define DCT_TIMING_REGS_VH

// command codes on the request and device command ports
`define DCT_CMD_NOP       4'h0
`define DCT_CMD_ACT       4'h1
`define DCT_CMD_PRE       4'h2
`define DCT_CMD_REFA      4'h3
`define DCT_CMD_REFI      4'h4
`define DCT_CMD_REFP      4'h5
`define DCT_CMD_REF1      4'h6
`define DCT_CMD_LRR       4'h7
`define DCT_CMD_RD        4'h8
`define DCT_CMD_WR        4'h9
`define DCT_CMD_WRM       4'hA

// speed bin codes
`define DCT_BIN_A         2'h0
`define DCT_BIN_B         2'h1
`define DCT_BIN_C         2'h2

// per-bin minimums packed as {C, B, A}, 6 bits each, in cycles
`define DCT_T_RC          {6'h18, 6'h14, 6'h10}
`define DCT_T_RC_ERAW     {6'h1C, 6'h1C, 6'h17}
`define DCT_T_RAS         {6'h11, 6'h0D, 6'h0A}
`define DCT_T_RCDR        {6'h07, 6'h07, 6'h05}
`define DCT_T_RCDW        {6'h03, 6'h03, 6'h01}
`define DCT_T_CAC         {6'h07, 6'h07, 6'h06}
`define DCT_T_WR          {6'h0A, 6'h0A, 6'h09}
`define DCT_T_RW          {6'h09, 6'h09, 6'h00}
`define DCT_T_RDP         {6'h04, 6'h04, 6'h03}
`define DCT_T_WRP         {6'h0C, 6'h0C, 6'h0A}
`define DCT_T_DR          {6'h07, 6'h07, 6'h06}
`define DCT_T_DP          {6'h09, 6'h09, 6'h07}
`define DCT_T_LRR         {6'h18, 6'h14, 6'h10}

// bin-independent minimums
`define DCT_T_PP          6'h04
`define DCT_T_PP_D        6'h01
`define DCT_T_RR          6'h04
`define DCT_T_CWD         6'h03
`define DCT_T_CC          6'h02
`define DCT_T_BUB         6'h03
`define DCT_T_WRD_MIN     6'h02
`define DCT_T_PDN_ENTRY   6'h10

// history counter saturation
`define DCT_CNT_MAX       6'h3F
// read-return capture pipeline depth
`define DCT_PIPE_W        16

`endif

// ---- dv/dct_host_ctrl_asserts.sv ----
// assertion checker for the host command scheduler
`timescale 1ns/1ps
`default_nettype none
`include "dct_timing_regs.vh"
module dct_host_ctrl_chk (
  input wire logic        core_clk_in,
  input wire logic        arst_n_in,
  input wire logic [1:0]  bin_sel_in,
  input wire logic        req_valid_in,
  input wire logic [3:0]  req_cmd_in,
  input wire logic [31:0] req_wdata_in,
  input wire logic        req_ready_out,
  input wire logic        dev_cmd_valid_out,
  input wire logic [3:0]  dev_cmd_out,
  input wire logic [2:0]  dev_bank_out,
  input wire logic [15:0] dq_out,
  input wire logic        dq_oe_out,
  input wire logic        dev_pdn_out,
  input wire logic        pdn_state_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!arst_n_in);
  logic [5:0] sa_r [8];
  logic [5:0] sr_r;
  logic [5:0] sw_r;
  logic       ws_r;
  int         trc;
  int         tras;
  int         tcdr;
  int         trw;
  int         twr;
  wire [3:0] c = dev_cmd_out;
  wire act_i = dev_cmd_valid_out && (c == `DCT_CMD_ACT || c == `DCT_CMD_REFA || c == `DCT_CMD_REFI);
  wire pre_i = dev_cmd_valid_out && (c == `DCT_CMD_PRE || c == `DCT_CMD_REFP);
  wire rd_i  = dev_cmd_valid_out && c == `DCT_CMD_RD;
  wire wr_i  = dev_cmd_valid_out && (c == `DCT_CMD_WR || c == `DCT_CMD_WRM);
  wire bc    = bin_sel_in == `DCT_BIN_B || bin_sel_in == `DCT_BIN_C;
  // per-bin minimums
  always_comb begin
    trc  = bc ? (bin_sel_in == `DCT_BIN_B ? 20 : 24) : 16;
    tras = bc ? (bin_sel_in == `DCT_BIN_B ? 13 : 17) : 10;
    tcdr = bc ? 7 : 5;
    trw  = bc ? 9 : 8;
    twr  = bc ? 10 : 9;
  end
  // cycles since last issue, saturating, and bank set of the last write
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      for (int i = 0; i < 8; i++) sa_r[i] <= 6'h3F;
      sr_r <= 6'h3F;
      sw_r <= 6'h3F;
      ws_r <= 1'b0;
    end else begin
      for (int i = 0; i < 8; i++)
        sa_r[i] <= (act_i && dev_bank_out == i) ? 6'h01 : sa_r[i] + {5'h0, sa_r[i] != 6'h3F};
      sr_r <= rd_i ? 6'h01 : sr_r + {5'h0, sr_r != 6'h3F};
      sw_r <= wr_i ? 6'h01 : sw_r + {5'h0, sw_r != 6'h3F};
      ws_r <= wr_i ? dev_bank_out[0] : ws_r;
    end
  end
  a_row_cycle: assert property (act_i |-> sa_r[dev_bank_out] >= trc)
    else $error("row cycle short");
  a_act_to_pre: assert property (pre_i |-> sa_r[dev_bank_out] >= tras)
    else $error("activate to precharge short");
  a_act_spacing: assert property (act_i |=> !act_i [*3])
    else $error("activate spacing short");
  a_act_to_rd: assert property (rd_i |-> sa_r[dev_bank_out] >= tcdr)
    else $error("activate to read short");
  a_col_spacing: assert property ((rd_i |=> !rd_i) and (wr_i |=> !wr_i))
    else $error("column spacing short");
  a_rd_to_wr: assert property (wr_i |-> sr_r >= trw)
    else $error("read to write short");
  a_wr_to_rd: assert property (rd_i |-> sw_r >= twr || (dev_bank_out[0] != ws_r
    && sw_r >= 2 && !(sw_r inside {6'h03, 6'h05, 6'h07})))
    else $error("write to read spacing bad");
  a_wdata_place: assert property (wr_i |-> ##3 dq_oe_out && dq_out == $past(req_wdata_in[15:0], 4)
    ##1 dq_oe_out && dq_out == $past(req_wdata_in[31:16], 5))
    else $error("write data misplaced");
  a_take_issue: assert property (req_valid_in && req_ready_out && req_cmd_in != 4'h0
    |=> dev_cmd_valid_out && dev_cmd_out == $past(req_cmd_in))
    else $error("taken request not issued");
  a_pdn_entry: assert property ($rose(dev_pdn_out) |-> ##[1:16] pdn_state_out)
    else $error("power down entry slow");
  c_read: cover property (rd_i);
  c_write: cover property (wr_i);
  c_pdn: cover property ($rose(pdn_state_out));
endmodule // dct_host_ctrl_chk
bind dct_host_ctrl dct_host_ctrl_chk u_chk (.core_clk_in, .arst_n_in, .bin_sel_in,
  .req_valid_in, .req_cmd_in, .req_wdata_in, .req_ready_out, .dev_cmd_valid_out,
  .dev_cmd_out, .dev_bank_out, .dq_out, .dq_oe_out, .dev_pdn_out, .pdn_state_out);
`default_nettype wire

// ---- dv/dct_dev_model.sv ----
// behavioural device: read data return on the data pins
`timescale 1ns/1ps
`default_nettype none
`include "dct_timing_regs.vh"
module dct_dev_model (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic [1:0]  bin_in,
  input  wire logic        cmd_valid_in,
  input  wire logic [3:0]  cmd_in,
  input  wire logic [2:0]  bank_in,
  input  wire logic        pdn_in,
  output var  logic [15:0] dq_out
);
  logic [3:0] pipe_r [16];
  int         tcac;
  always_comb tcac = (bin_in == `DCT_BIN_B || bin_in == `DCT_BIN_C) ? 7 : 6;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < 16; i++) pipe_r[i] <= 4'h0;
      dq_out <= 16'h5A5A;
    end else begin
      pipe_r[0] <= {cmd_valid_in && !pdn_in && cmd_in == `DCT_CMD_RD, bank_in};
      for (int i = 1; i < 16; i++) pipe_r[i] <= pipe_r[i-1];
      if (pipe_r[tcac-2][3]) dq_out <= {13'h1A3, pipe_r[tcac-2][2:0]};
      else if (pipe_r[tcac-1][3]) dq_out <= ~{13'h1A3, pipe_r[tcac-1][2:0]};
      else dq_out <= ~dq_out;
    end
  end
endmodule // dct_dev_model
`default_nettype wire

// ---- dv/tb_dram_core_command_timing.sv ----
// self-checking bench for the host command scheduler
`timescale 1ns/1ps
`default_nettype none
`include "dct_timing_regs.vh"
module tb_dram_core_command_timing;
  logic        core_clk_in = 1'b0;
  logic        arst_n_in = 1'b0;
  logic        eraw_en_in = 1'b0;
  logic        req_valid_in = 1'b0;
  logic        pdn_req_in = 1'b0;
  logic [1:0]  bin_sel_in = 2'h0;
  logic [3:0]  req_cmd_in = 4'h0;
  logic [2:0]  req_bank_in = 3'h0;
  logic [31:0] req_wdata_in = 32'h0;
  wire  [15:0] dq_in;
  wire  [15:0] dq_out;
  wire  [31:0] rd_data_out;
  wire  [3:0]  dev_cmd_out;
  wire  [2:0]  dev_bank_out;
  wire         req_ready_out, rd_valid_out, pdn_state_out, dev_pdn_out;
  wire         dev_cmd_valid_out, dq_oe_out;
  int          mismatches = 0;
  int          checks = 0;
  int          cyc = 0;
  int          rv_cyc [$];
  logic [31:0] rv_dat [$];
  always #2 core_clk_in = ~core_clk_in;
  always @(posedge core_clk_in) begin
    cyc <= cyc + 1;
    if (rd_valid_out === 1'b1) begin
      rv_cyc.push_back(cyc);
      rv_dat.push_back(rd_data_out);
    end
  end
  dct_host_ctrl dut_u (.core_clk_in, .arst_n_in, .bin_sel_in, .eraw_en_in, .req_valid_in,
    .req_cmd_in, .req_bank_in, .req_wdata_in, .req_ready_out, .rd_data_out, .rd_valid_out,
    .pdn_req_in, .pdn_state_out, .dev_pdn_out, .dev_cmd_valid_out, .dev_cmd_out,
    .dev_bank_out, .dq_in, .dq_out, .dq_oe_out);
  dct_dev_model u_dev (.clk_in(core_clk_in), .rst_n_in(arst_n_in), .bin_in(bin_sel_in),
    .cmd_valid_in(dev_cmd_valid_out), .cmd_in(dev_cmd_out), .bank_in(dev_bank_out),
    .pdn_in(dev_pdn_out), .dq_out(dq_in));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  function automatic int bv(int a, int b, int c);
    return bin_sel_in == `DCT_BIN_B ? b : (bin_sel_in == `DCT_BIN_C ? c : a);
  endfunction
  function automatic logic [31:0] exp_rd(input logic [2:0] b);
    return {~{13'h1A3, b}, 13'h1A3, b};
  endfunction
  // one request held until taken; t is the taking edge
  task automatic issue(input logic [3:0] c, input logic [2:0] b, output int t);
    int n;
    n = 0;
    @(posedge core_clk_in);
    req_valid_in <= 1'b1;
    req_cmd_in <= c;
    req_bank_in <= b;
    req_wdata_in <= $urandom;
    @(negedge core_clk_in);
    while (req_ready_out !== 1'b1 && n < 200) begin
      n++;
      @(negedge core_clk_in);
    end
    if (n == 200) begin
      mismatches++;
      report_and_stop;
    end
    @(posedge core_clk_in);
    t = cyc;
    req_valid_in <= 1'b0;
  endtask
  task automatic run_bin(input logic [1:0] bin);
    int t [12];
    int n;
    logic [7:0] op;
    logic [3:0] c;
    logic [2:0] b;
    n = 0;
    @(posedge core_clk_in);
    arst_n_in <= 1'b0;
    bin_sel_in <= bin;
    eraw_en_in <= 1'($urandom);
    repeat (12) @(posedge core_clk_in);
    // drop returns of reads cut off by the reset
    rv_cyc.delete();
    rv_dat.delete();
    arst_n_in <= 1'b1;
    issue(`DCT_CMD_ACT, 3'h0, t[0]);
    issue(`DCT_CMD_ACT, 3'h1, t[1]);
    check("act gap", t[1] - t[0], 4);
    issue(`DCT_CMD_RD, 3'h0, t[2]);
    // bin A read waits on activate spacing plus the two-cycle request turnaround
    check("act rd", t[2] - t[0], bv(4 + 2, 7, 7));
    issue(`DCT_CMD_WRM, 3'h0, t[3]);
    check("rd wr", t[3] - t[2], bv(8, 9, 9));
    issue(`DCT_CMD_RD, 3'h1, t[4]);
    check("wr rd xset", t[4] - t[3], 2);
    issue(`DCT_CMD_PRE, 3'h1, t[5]);
    check("rd pre", t[5] - t[4], bv(3, 4, 4));
    issue(`DCT_CMD_PRE, 3'h0, t[6]);
    check("wr pre", t[6] - t[3], bv(10, 12, 12));
    issue(`DCT_CMD_REF1, 3'h0, t[7]);
    issue(`DCT_CMD_LRR, 3'h0, t[8]);
    check("ref lrr", t[8] - t[7], bv(16, 20, 24));
    issue(`DCT_CMD_LRR, 3'h0, t[9]);
    check("lrr lrr", t[9] - t[8], bv(16, 20, 24));
    issue(`DCT_CMD_ACT, 3'h2, t[10]);
    issue(`DCT_CMD_WR, 3'h2, t[11]);
    check("act wr", t[11] - t[10], bv(2, 3, 3));
    issue(`DCT_CMD_RD, 3'h2, t[0]);
    check("wr rd", t[0] - t[11], bv(9, 10, 10));
    while (rv_cyc.size() < 3 && n < 40) begin
      n++;
      @(posedge core_clk_in);
    end
    check("rd count", rv_cyc.size(), 3);
    t[1] = t[4];
    t[3] = t[0];
    for (int i = 0; i < 3 && rv_cyc.size() > 0; i++) begin
      check("rd lat", rv_cyc.pop_front() - t[2 * i + 2 - (i == 2 ? 3 : 0)], bv(11, 12, 12));
      check("rd data", rv_dat.pop_front(), exp_rd(3'(i)));
    end
    op = 8'h04;
    repeat (60) begin
      b = 3'($urandom);
      c = op[b] ? 4'($urandom_range(`DCT_CMD_WRM, `DCT_CMD_RD)) : `DCT_CMD_ACT;
      if (op[b] && $urandom_range(3, 0) == 0) c = `DCT_CMD_PRE;
      issue(c, b, t[5]);
      op[b] = c != `DCT_CMD_PRE;
    end
  endtask
  initial begin
    int n;
    void'($urandom(14687));
    for (int i = 0; i < 4; i++) run_bin(2'(i));
    n = 0;
    @(posedge core_clk_in);
    pdn_req_in <= 1'b1;
    @(negedge core_clk_in);
    while (dev_pdn_out !== 1'b1 && n < 8) begin
      n++;
      @(negedge core_clk_in);
    end
    n = 0;
    while (pdn_state_out !== 1'b1 && n < 40) begin
      n++;
      @(negedge core_clk_in);
    end
    check("pdn entry", n <= 16, 1);
    check("pdn refuse", req_ready_out, 0);
    @(posedge core_clk_in);
    pdn_req_in <= 1'b0;
    @(posedge core_clk_in);
    @(negedge core_clk_in);
    check("pdn exit", pdn_state_out, 0);
    report_and_stop;
  end
endmodule // tb_dram_core_command_timing
`default_nettype wire
